// ### core/dual_interval_event_counter.v
// Purpose: two 8-bit modulo counters with wave outputs and match flags
// Assumes: one clock core_clk is fcc; register port is synchronous
// Notes:   count registers freeze while a read of them is in progress
//          reserved select codes give no count pulses at all
//          a start beats a match that lands in the same cycle
`include "event_counter_defs.vh"

module dual_interval_event_counter #(
    parameter WIDTH = 8
) (
    input  wire              core_clk,
    input  wire              rst,
    input  wire [11:0]       addr,
    input  wire              wr_en,
    input  wire              rd_en,
    input  wire              bit_wr_en,
    input  wire [2:0]        bit_sel,
    input  wire              bit_val,
    input  wire [WIDTH-1:0]  wr_data,
    output reg  [WIDTH-1:0]  rd_data,
    input  wire              event_input_pin,
    input  wire              clock_timer_overflow,
    output reg               chan0_wave_pin,
    output reg               chan1_wave_pin,
    output reg               chan0_match_flag,
    output reg               chan1_match_flag
);

////////////////////////////////////////////////////////////////////////////
wire [WIDTH-1:0] chan_control_reg [0:1];
reg  [4:0]       control_fld_reg  [0:1];
reg  [WIDTH-1:0] count_value_reg  [0:1];
reg  [WIDTH-1:0] compare_limit_reg [0:1];
reg  [1:0]       wave_flipflop;
reg  [1:0]       pin_enable_reg;
reg  [`PRESCALE_WIDTH-1:0] prescale_reg;
reg  [`PRESCALE_WIDTH-1:0] prescale_prev_reg;
reg              ev_sync1_reg;
reg              ev_sync2_reg;
reg              ev_prev_reg;
reg              ovf_prev_reg;
reg  [WIDTH-1:0] rd_data_next;
reg              chan0_wave_next;
reg              chan1_wave_next;

// reset image of the stored field, bits 6..2 of the control byte
localparam [7:0] CONTROL_RESET_BYTE = `CONTROL_RESET;
localparam [4:0] CONTROL_RESET_FLD  =
                 CONTROL_RESET_BYTE[`SEL_HI:`RUN_BIT];

wire hit0 = (addr == `CHAN0_CONTROL_ADDR);
wire hit1 = (addr == `CHAN1_CONTROL_ADDR);

// enable flags, one per channel
wire chan0_pin_enable = pin_enable_reg[0];
wire chan1_pin_enable = pin_enable_reg[1];

// control held as bits 6..2; bits 7,1,0 read zero
assign chan_control_reg[0] = {1'b0, control_fld_reg[0], 2'b00};
assign chan_control_reg[1] = {1'b0, control_fld_reg[1], 2'b00};

// stored field: [4:2] select, [1] always zero, [0] run
wire [2:0] sel0 = control_fld_reg[0][4:2];
wire [2:0] sel1 = control_fld_reg[1][4:2];
wire       run0 = control_fld_reg[0][0];
wire       run1 = control_fld_reg[1][0];

////////////////////////////////////////////////////////////////////////////
// start request decode: byte write with bit 3 or single-bit set of bit 3
wire st0_byte = wr_en & hit0 & wr_data[`START_BIT];
wire st1_byte = wr_en & hit1 & wr_data[`START_BIT];
wire st0_bit  = bit_wr_en & hit0 & (bit_sel == `START_BIT) & bit_val;
wire st1_bit  = bit_wr_en & hit1 & (bit_sel == `START_BIT) & bit_val;
// a bit write of 0 to the start bit has no effect
wire [1:0] start_req = {st1_byte | st1_bit, st0_byte | st0_bit};

////////////////////////////////////////////////////////////////////////////
// prescaler rising-bit edges give one-cycle fcc/2^(k+1) enables
always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        prescale_reg      <= {`PRESCALE_WIDTH{1'b0}};
        prescale_prev_reg <= {`PRESCALE_WIDTH{1'b0}};
    end else begin
        prescale_reg      <= prescale_reg + 1'b1;
        prescale_prev_reg <= prescale_reg;
    end
end

wire [`PRESCALE_WIDTH-1:0] tick = prescale_reg & ~prescale_prev_reg;

// the eight prescaler enables that the select codes choose between
wire c0_div_a = tick[`C0_TAP_A];
wire c0_div_b = tick[`C0_TAP_B];
wire c0_div_c = tick[`C0_TAP_C];
wire c0_div_d = tick[`C0_TAP_D];
wire c1_div_a = tick[`C1_TAP_A];
wire c1_div_b = tick[`C1_TAP_B];
wire c1_div_c = tick[`C1_TAP_C];
wire c1_div_d = tick[`C1_TAP_D];

////////////////////////////////////////////////////////////////////////////
// event input passes two flops before the edge detector
always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        ev_sync1_reg <= 1'b0;
        ev_sync2_reg <= 1'b0;
        ev_prev_reg  <= 1'b0;
    end else begin
        ev_sync1_reg <= event_input_pin;
        ev_sync2_reg <= ev_sync1_reg;
        ev_prev_reg  <= ev_sync2_reg;
    end
end

// overflow comes from on-chip logic on this clock, so an edge flop will do
always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        ovf_prev_reg <= 1'b0;
    end else begin
        ovf_prev_reg <= clock_timer_overflow;
    end
end

wire ev_rise  = ev_sync2_reg & ~ev_prev_reg;
wire ev_fall  = ~ev_sync2_reg & ev_prev_reg;
wire ovf_rise = clock_timer_overflow & ~ovf_prev_reg;

////////////////////////////////////////////////////////////////////////////
reg count_pulse0;
reg count_pulse1;

// channel 0: event edges or one of four prescaler taps
always @* begin
    case (sel0)
        `SEL_EDGE_RISE: count_pulse0 = ev_rise;
        `SEL_EDGE_FALL: count_pulse0 = ev_fall;
        `SEL_DIV_A:     count_pulse0 = c0_div_a;
        `SEL_DIV_B:     count_pulse0 = c0_div_b;
        `SEL_DIV_C:     count_pulse0 = c0_div_c;
        `SEL_DIV_D:     count_pulse0 = c0_div_d;
        default:        count_pulse0 = 1'b0;
    endcase
end

// channel 1: overflow edge or one of four prescaler taps
always @* begin
    case (sel1)
        `SEL_EDGE_RISE: count_pulse1 = ovf_rise;
        `SEL_DIV_A:     count_pulse1 = c1_div_a;
        `SEL_DIV_B:     count_pulse1 = c1_div_b;
        `SEL_DIV_C:     count_pulse1 = c1_div_c;
        `SEL_DIV_D:     count_pulse1 = c1_div_d;
        default:        count_pulse1 = 1'b0;
    endcase
end

// a read of a count register holds it for that cycle
wire hold0 = rd_en & (addr == `CHAN0_COUNT_ADDR);
wire hold1 = rd_en & (addr == `CHAN1_COUNT_ADDR);

// compare and gate per channel
wire cmp_eq0 = (count_value_reg[0] == compare_limit_reg[0]);
wire cmp_eq1 = (count_value_reg[1] == compare_limit_reg[1]);
wire pulse0  = count_pulse0 & run0 & ~hold0;
wire pulse1  = count_pulse1 & run1 & ~hold1;

wire [1:0] pulse = {pulse1, pulse0};
wire [1:0] match = {pulse1 & cmp_eq1, pulse0 & cmp_eq0};

////////////////////////////////////////////////////////////////////////////
// control registers: start bit is never stored, so it reads zero
always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        control_fld_reg[0]   <= CONTROL_RESET_FLD;
        control_fld_reg[1]   <= CONTROL_RESET_FLD;
        pin_enable_reg       <= 2'b00;
        compare_limit_reg[0] <= {WIDTH{1'b0}};
        compare_limit_reg[1] <= {WIDTH{1'b0}};
    end else begin
        // byte write of a control register; the start bit is dropped
        if (wr_en & hit0) begin
            control_fld_reg[0] <= {wr_data[`SEL_HI:`SEL_LO], 1'b0,
                                   wr_data[`RUN_BIT]};
        end
        if (wr_en & hit1) begin
            control_fld_reg[1] <= {wr_data[`SEL_HI:`SEL_LO], 1'b0,
                                   wr_data[`RUN_BIT]};
        end

        // single-bit access reaches the run bit only
        if (bit_wr_en & hit0 & (bit_sel == `RUN_BIT)) begin
            control_fld_reg[0][0] <= bit_val;
        end
        if (bit_wr_en & hit1 & (bit_sel == `RUN_BIT)) begin
            control_fld_reg[1][0] <= bit_val;
        end

        // modulo values
        if (wr_en & (addr == `CHAN0_LIMIT_ADDR)) begin
            compare_limit_reg[0] <= wr_data;
        end
        if (wr_en & (addr == `CHAN1_LIMIT_ADDR)) begin
            compare_limit_reg[1] <= wr_data;
        end

        // pin enables: a bit write in the same cycle wins over a byte
        if (wr_en & (addr == `PIN_ENABLE_ADDR)) begin
            pin_enable_reg <= wr_data[1:0];
        end
        if (bit_wr_en & (addr == `PIN_ENABLE_ADDR) & ~bit_sel[2]
            & ~bit_sel[1]) begin
            pin_enable_reg[bit_sel[0]] <= bit_val;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// counters and wave flops; start wins over a same-cycle match
always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        count_value_reg[0] <= {WIDTH{1'b0}};
        count_value_reg[1] <= {WIDTH{1'b0}};
        wave_flipflop      <= 2'b00;
    end else begin
        // channel 0
        if (start_req[0]) begin
            count_value_reg[0] <= {WIDTH{1'b0}};
            wave_flipflop[0]   <= 1'b0;
        end else if (match[0]) begin
            count_value_reg[0] <= {WIDTH{1'b0}};
            wave_flipflop[0]   <= ~wave_flipflop[0];
        end else if (pulse[0]) begin
            count_value_reg[0] <= count_value_reg[0] + 1'b1;
        end

        // channel 1
        if (start_req[1]) begin
            count_value_reg[1] <= {WIDTH{1'b0}};
            wave_flipflop[1]   <= 1'b0;
        end else if (match[1]) begin
            count_value_reg[1] <= {WIDTH{1'b0}};
            wave_flipflop[1]   <= ~wave_flipflop[1];
        end else if (pulse[1]) begin
            count_value_reg[1] <= count_value_reg[1] + 1'b1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// match flags: start clears, a match sets, software clears by writing 0
// to the flag's bit; a match in the cycle of a software clear keeps the
// flag set so that no interval is lost
wire       flag_wr  = wr_en & (addr == `FLAG_STATUS_ADDR);
wire [1:0] flag_clr = {flag_wr, flag_wr} & ~wr_data[1:0];

always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        chan0_match_flag <= 1'b0;
        chan1_match_flag <= 1'b0;
    end else begin
        // channel 0
        if (start_req[0]) begin
            chan0_match_flag <= 1'b0;
        end else if (match[0]) begin
            chan0_match_flag <= 1'b1;
        end else if (flag_clr[0]) begin
            chan0_match_flag <= 1'b0;
        end

        // channel 1
        if (start_req[1]) begin
            chan1_match_flag <= 1'b0;
        end else if (match[1]) begin
            chan1_match_flag <= 1'b1;
        end else if (flag_clr[1]) begin
            chan1_match_flag <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// read data next value; an unmapped address reads zero
always @* begin
    rd_data_next = rd_data;
    if (rd_en) begin
        case (addr)
            `CHAN0_CONTROL_ADDR: rd_data_next = chan_control_reg[0];
            `CHAN1_CONTROL_ADDR: rd_data_next = chan_control_reg[1];
            `CHAN0_COUNT_ADDR:   rd_data_next = count_value_reg[0];
            `CHAN1_COUNT_ADDR:   rd_data_next = count_value_reg[1];
            `CHAN0_LIMIT_ADDR:   rd_data_next = compare_limit_reg[0];
            `CHAN1_LIMIT_ADDR:   rd_data_next = compare_limit_reg[1];
            `PIN_ENABLE_ADDR:    rd_data_next = {6'h00, pin_enable_reg};
            `FLAG_STATUS_ADDR:   rd_data_next = {6'h00, chan1_match_flag,
                                                 chan0_match_flag};
            default:             rd_data_next = {WIDTH{1'b0}};
        endcase
    end
end

// pins are registered so an enable change cannot glitch them; the cost
// is one cycle of lag behind the wave flops
always @* begin
    chan0_wave_next = wave_flipflop[0] & chan0_pin_enable;
    chan1_wave_next = wave_flipflop[1] & chan1_pin_enable;
end

always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        chan0_wave_pin <= 1'b0;
        chan1_wave_pin <= 1'b0;
        rd_data        <= {WIDTH{1'b0}};
    end else begin
        chan0_wave_pin <= chan0_wave_next;
        chan1_wave_pin <= chan1_wave_next;
        rd_data        <= rd_data_next;
    end
end

endmodule // dual_interval_event_counter

// ### core/event_counter_defs.vh
// Purpose: constants for the dual interval event counter
// Assumes: byte-wide memory-mapped register port, 12-bit addresses
// Notes:   prescaler taps are bit indices of a free-running divider
`ifndef EVENT_COUNTER_DEFS_VH
`define EVENT_COUNTER_DEFS_VH

`define CHAN0_CONTROL_ADDR   12'hFA0
`define CHAN1_CONTROL_ADDR   12'hFA8
`define CHAN0_COUNT_ADDR     12'hFA2
`define CHAN1_COUNT_ADDR     12'hFAA
`define CHAN0_LIMIT_ADDR     12'hFA4
`define CHAN1_LIMIT_ADDR     12'hFAC
`define PIN_ENABLE_ADDR      12'hFA6
`define FLAG_STATUS_ADDR     12'hFAE

`define CONTROL_RESET        8'h00
`define CONTROL_WRITE_MASK   8'h7C
`define START_BIT            3
`define RUN_BIT              2
`define SEL_HI               6
`define SEL_LO               4

`define SEL_EDGE_RISE        3'h0
`define SEL_EDGE_FALL        3'h1
`define SEL_DIV_A            3'h4
`define SEL_DIV_B            3'h5
`define SEL_DIV_C            3'h6
`define SEL_DIV_D            3'h7

`define PRESCALE_WIDTH       12
`define C0_TAP_A             9
`define C0_TAP_B             7
`define C0_TAP_C             5
`define C0_TAP_D             3
`define C1_TAP_A             11
`define C1_TAP_B             9
`define C1_TAP_C             7
`define C1_TAP_D             5

`endif

// ### dv/dual_interval_event_counter_tb_top.sv
// Purpose: directed bench for the dual interval event counter
// Assumes: a flag status write of 00 clears both flags
// Notes:   prescaler intervals use limit 01 to keep the run short
`include "event_counter_defs.vh"
module dual_interval_event_counter_tb_top;
timeunit 1ns;
timeprecision 1ps;
logic        core_clk = 1'b0, rst = 1'b1, bit_val = 1'b0;
logic        wr_en = 1'b0, rd_en = 1'b0, bit_wr_en = 1'b0;
logic        event_input_pin = 1'b0, clock_timer_overflow = 1'b0;
logic [11:0] addr = 12'h000;
logic [2:0]  bit_sel = 3'h0;
logic [7:0]  wr_data = 8'h00, rd_data, v, w;
logic        chan0_wave_pin, chan1_wave_pin;
logic        chan0_match_flag, chan1_match_flag;
int          fails = 0, compares = 0;
always #2 core_clk = ~core_clk;
dual_interval_event_counter dual_interval_event_counter_inst (
    .core_clk(core_clk), .rst(rst), .addr(addr), .wr_en(wr_en),
    .rd_en(rd_en), .bit_wr_en(bit_wr_en), .bit_sel(bit_sel),
    .bit_val(bit_val), .wr_data(wr_data), .rd_data(rd_data),
    .event_input_pin(event_input_pin),
    .clock_timer_overflow(clock_timer_overflow),
    .chan0_wave_pin(chan0_wave_pin), .chan1_wave_pin(chan1_wave_pin),
    .chan0_match_flag(chan0_match_flag),
    .chan1_match_flag(chan1_match_flag));
////////////////////////////////////////////////////////////////////////
task automatic conclude;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
        $display("== PASSED ==");
    end else begin
        $display("== FAILED ==");
    end
    $finish;
endtask
task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
        fails++;
        $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
endtask
function automatic logic flg(input int ch);
    return ch ? chan1_match_flag : chan0_match_flag;
endfunction
function automatic logic pin(input int ch);
    return ch ? chan1_wave_pin : chan0_wave_pin;
endfunction
task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
endtask
task automatic bw(input logic [11:0] a, input logic [2:0] s, input logic b);
    @(posedge core_clk);
    addr <= a;
    bit_sel <= s;
    bit_val <= b;
    bit_wr_en <= 1'b1;
    @(posedge core_clk);
    bit_wr_en <= 1'b0;
endtask
task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1 d = rd_data;
endtask
// bounded wait so a dead counter ends the run instead of hanging
task automatic wait_flag(input int ch, input int lim);
    for (int i = 0; i <= lim; i++) begin
        @(posedge core_clk);
        #1;
        if (flg(ch) === 1'b1) return;
    end
    fails++;
    $display("wrong value at %0t: match flag never set", $time);
    conclude();
endtask
task automatic ivl(input int ch, input logic [2:0] c, input int div);
    logic [11:0] ca;
    realtime     t0;
    ca = ch ? `CHAN1_CONTROL_ADDR : `CHAN0_CONTROL_ADDR;
    wr(ch ? `CHAN1_LIMIT_ADDR : `CHAN0_LIMIT_ADDR, 8'h01);
    wr(ca, {1'b0, c, 4'hC});
    #1 chk(16'(flg(ch)), 16'h0000);
    rd(ca, v);
    chk({8'h00, v}, {9'h000, c, 4'h4});
    wait_flag(ch, 4 * div);
    t0 = $realtime;
    repeat (2) @(posedge core_clk);
    #1 chk(16'(pin(ch)), 16'h0001);
    wr(`FLAG_STATUS_ADDR, 8'h00);
    wait_flag(ch, 4 * div);
    chk(16'(int'(($realtime - t0) / 4.0)), 16'(2 * div));
    repeat (2) @(posedge core_clk);
    #1 chk(16'(pin(ch)), 16'h0000);
endtask
task automatic ev(input int ch, input logic [2:0] c);
    wr(ch ? `CHAN1_LIMIT_ADDR : `CHAN0_LIMIT_ADDR, 8'h02);
    wr(ch ? `CHAN1_CONTROL_ADDR : `CHAN0_CONTROL_ADDR, {1'b0, c, 4'hC});
    for (int k = 0; k < 3; k++) begin
        @(posedge core_clk);
        event_input_pin <= (ch == 0);
        clock_timer_overflow <= (ch == 1);
        repeat (6) @(posedge core_clk);
        #1 chk(16'(flg(ch)), 16'((k == 2) && (c == 3'h0)));
        @(posedge core_clk);
        event_input_pin <= 1'b0;
        clock_timer_overflow <= 1'b0;
        repeat (6) @(posedge core_clk);
    end
    #1 chk(16'(flg(ch)), 16'h0001);
endtask
////////////////////////////////////////////////////////////////////////
initial begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    rd(`CHAN0_CONTROL_ADDR, v);
    chk({8'h00, v}, 16'h0000);
    rd(`CHAN1_CONTROL_ADDR, v);
    chk({8'h00, v}, 16'h0000);
    rd(12'h000, v);
    chk({8'h00, v}, 16'h0000);
    wr(`CHAN1_CONTROL_ADDR, 8'hF3);
    rd(`CHAN1_CONTROL_ADDR, v);
    chk({8'h00, v}, 16'h0070);
    $display("test reset and map done");
    wr(`PIN_ENABLE_ADDR, 8'h03);
    for (int c = 4; c < 8; c++) begin
        ivl(1, 3'(c), 4096 >> (2 * (c - 4)));
        ivl(0, 3'(c), 1024 >> (2 * (c - 4)));
    end
    $display("test intervals done");
    wr(`FLAG_STATUS_ADDR, 8'h00);
    wait_flag(0, 100);
    wr(`CHAN0_CONTROL_ADDR, 8'h70);
    rd(`CHAN0_COUNT_ADDR, v);
    repeat (40) @(posedge core_clk);
    rd(`CHAN0_COUNT_ADDR, w);
    chk({8'h00, w}, {8'h00, v});
    bw(`CHAN0_CONTROL_ADDR, 3'h3, 1'b1);
    #1 chk(16'(chan0_match_flag), 16'h0000);
    repeat (40) @(posedge core_clk);
    rd(`CHAN0_COUNT_ADDR, v);
    chk({8'h00, v}, 16'h0000);
    chk(16'(chan0_wave_pin), 16'h0000);
    bw(`CHAN0_CONTROL_ADDR, 3'h2, 1'b1);
    wait_flag(0, 100);
    $display("test stop and start done");
    ev(0, 3'h0);
    ev(0, 3'h1);
    ev(1, 3'h0);
    wr(`PIN_ENABLE_ADDR, 8'h00);
    repeat (2) @(posedge core_clk);
    #1 chk({14'h0000, chan1_wave_pin, chan0_wave_pin}, 16'h0000);
    $display("test events and pins done");
    conclude();
end
endmodule // dual_interval_event_counter_tb_top

// ### dv/event_counter_chk.sv
// Purpose: port checks for the dual interval event counter
// Assumes: register map of event_counter_defs.vh
// Notes:   pin checks allow for the registered pin stage
`include "event_counter_defs.vh"
module event_counter_chk (
    input logic        core_clk,
    input logic        rst,
    input logic [11:0] addr,
    input logic        wr_en,
    input logic        rd_en,
    input logic        bit_wr_en,
    input logic [7:0]  wr_data,
    input logic [7:0]  rd_data,
    input logic        chan0_wave_pin,
    input logic        chan0_match_flag,
    input logic        chan1_match_flag
);
timeunit 1ns;
timeprecision 1ps;
default clocking cb @(posedge core_clk);
endclocking
default disable iff (rst);
////////////////////////////////////////////////////////////////////////
sequence s_start0;
    wr_en && addr == `CHAN0_CONTROL_ADDR && wr_data[`START_BIT];
endsequence
sequence s_start1;
    wr_en && addr == `CHAN1_CONTROL_ADDR && wr_data[`START_BIT];
endsequence
property p_start_flag0; s_start0 |=> !chan0_match_flag; endproperty
a_start_flag0: assert property (p_start_flag0)
    else $error("start left flag 0 set");
property p_start_flag1; s_start1 |=> !chan1_match_flag; endproperty
a_start_flag1: assert property (p_start_flag1)
    else $error("start left flag 1 set");
property p_start_wave0; s_start0 |-> ##2 !chan0_wave_pin; endproperty
a_start_wave0: assert property (p_start_wave0)
    else $error("start left wave 0 high");
// both control registers sit at offset 0 and 8 of the FAx page
property p_ctl_read;
    rd_en && addr[11:4] == 8'hFA && addr[2:0] == 3'h0 |=> !(rd_data & 8'h8B);
endproperty
a_ctl_read: assert property (p_ctl_read)
    else $error("control read shows unused or start bit");
property p_unmapped;
    rd_en && addr[11:4] != 8'hFA |=> rd_data == 8'h00;
endproperty
a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
property p_rd_hold; !rd_en |=> $stable(rd_data); endproperty
a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved without a read");
property p_flag_keep;
    chan0_match_flag && !wr_en && !bit_wr_en |=> chan0_match_flag;
endproperty
a_flag_keep: assert property (p_flag_keep)
    else $error("flag 0 dropped without a write");
property p_pin_off;
    wr_en && addr == `PIN_ENABLE_ADDR && !wr_data[0] |-> ##2 !chan0_wave_pin;
endproperty
a_pin_off: assert property (p_pin_off)
    else $error("wave 0 driven while disabled");
endmodule // event_counter_chk
bind dual_interval_event_counter event_counter_chk event_counter_chk_inst (
    .core_clk(core_clk), .rst(rst), .addr(addr), .wr_en(wr_en),
    .rd_en(rd_en), .bit_wr_en(bit_wr_en), .wr_data(wr_data),
    .rd_data(rd_data), .chan0_wave_pin(chan0_wave_pin),
    .chan0_match_flag(chan0_match_flag), .chan1_match_flag(chan1_match_flag));
